// file: rtl/atw_host.sv
`timescale 1ns/100ps
`default_nettype none
// host end: generates the serial clock, reads results, recovers from lost sync with the idle-high clock
module atw_host #(
    parameter int TIMEOUT_CYC = atw_pkg::CONV_MAX_CYC,
    parameter int HALF_CYC    = atw_pkg::SCK_HALF_CYC
) (
    // system
    input  wire logic                           clk,
    input  wire logic                           rst,
    // link
    atw_if.host                                 lnk,
    // user side
    input  wire logic                           cpol,
    output logic [atw_pkg::RESULT_BITS-1:0]     data,
    output logic                                data_valid,
    output logic                                recover_evt
);
    import atw_pkg::*;

    typedef enum {HS_WAIT, HS_READ, HS_TAIL, HS_CHECK, HS_RECOVER} atw_host_state_t;

    atw_host_state_t         st_r, st_nxt;
    logic [31:0]             tmo_r, tmo_nxt;
    logic [7:0]              div_r, div_nxt;
    logic                    sck_r, sck_nxt;
    logic [5:0]              edg_r, edg_nxt;
    logic [RESULT_BITS-1:0]  sh_r, sh_nxt;
    logic [RESULT_BITS-1:0]  dat_r, dat_nxt;
    logic                    vld_r, vld_nxt;
    logic                    rec_r, rec_nxt;
    logic                    sdo_m_r, sdo_s_r;
    logic                    tick;

    // data input synchroniser
    always_ff @(posedge clk) begin
        if (rst) begin
            sdo_m_r <= 1'b1;
            sdo_s_r <= 1'b1;
        end else begin
            sdo_m_r <= lnk.sdo;
            sdo_s_r <= sdo_m_r;
        end
    end

    assign tick = (div_r == 8'(HALF_CYC - 1));

    // clock generator and read sequencer
    always_comb begin
        st_nxt  = st_r;
        tmo_nxt = tmo_r;
        div_nxt = tick ? 8'h00 : div_r + 8'h01;
        sck_nxt = sck_r;
        edg_nxt = edg_r;
        sh_nxt  = sh_r;
        dat_nxt = dat_r;
        vld_nxt = 1'b0;
        rec_nxt = 1'b0;
        case (st_r)
            HS_WAIT: begin
                sck_nxt = cpol;
                edg_nxt = 6'h00;
                tmo_nxt = tmo_r + 32'h1;
                // R11: wait for data low (idle-high)
                // R8: idle-low uses own timing
                if ((cpol == CPOL_HIGH && !sdo_s_r) ||
                    (cpol == CPOL_LOW && tmo_r >= 32'(TIMEOUT_CYC - 1))) begin
                    st_nxt  = HS_READ;
                    tmo_nxt = 32'h0;
                    div_nxt = 8'h00;
                end else if (tmo_r >= 32'(TIMEOUT_CYC - 1)) begin
                    // R12: no status within max time
                    st_nxt  = HS_RECOVER;
                    tmo_nxt = 32'h0;
                end
            end
            HS_READ, HS_RECOVER: begin
                // R5: sixteen pulses, R14: sample on rise
                if (tick) begin
                    sck_nxt = ~sck_r;
                    edg_nxt = edg_r + 6'h01;
                    if (sck_nxt && st_r == HS_READ) begin
                        sh_nxt = {sh_r[RESULT_BITS-2:0], sdo_s_r};
                    end
                    if (edg_r == 6'(2 * RESULT_BITS - 1)) begin
                        edg_nxt = 6'h00;
                        if (st_r == HS_RECOVER) begin
                            rec_nxt = 1'b1;
                            st_nxt  = HS_WAIT;
                        end else if (cpol == CPOL_HIGH) begin
                            st_nxt = HS_TAIL;
                        end else begin
                            // R9: 16th fall already restarted it
                            dat_nxt = sh_nxt;
                            vld_nxt = 1'b1;
                            st_nxt  = HS_WAIT;
                        end
                    end
                end
            end
            HS_TAIL: begin
                // R6: 17th pulse
                if (tick) begin
                    sck_nxt = ~sck_r;
                    edg_nxt = edg_r + 6'h01;
                    if (edg_r == 6'h01) begin
                        edg_nxt = 6'h00;
                        st_nxt  = HS_CHECK;
                    end
                end
            end
            HS_CHECK: begin
                // R11: data must be high after read, else R12
                if (tick) begin
                    if (sdo_s_r) begin
                        dat_nxt = sh_r;
                        vld_nxt = 1'b1;
                        st_nxt  = HS_WAIT;
                    end else begin
                        st_nxt = HS_RECOVER;
                    end
                end
            end
            default: st_nxt = HS_WAIT;
        endcase
    end

    // register state
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r  <= HS_WAIT;
            tmo_r <= 32'h0;
            div_r <= 8'h00;
            sck_r <= 1'b1;
            edg_r <= 6'h00;
            sh_r  <= '0;
            dat_r <= '0;
            vld_r <= 1'b0;
            rec_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            tmo_r <= tmo_nxt;
            div_r <= div_nxt;
            sck_r <= sck_nxt;
            edg_r <= edg_nxt;
            sh_r  <= sh_nxt;
            dat_r <= dat_nxt;
            vld_r <= vld_nxt;
            rec_r <= rec_nxt;
        end
    end

    // R1: select is grounded in the interface
    assign lnk.sck     = sck_r;
    assign data        = dat_r;
    assign data_valid  = vld_r;
    assign recover_evt = rec_r;
endmodule
`default_nettype wire

// file: rtl/atw_pkg.sv
package atw_pkg;
    // result width and conversion timing
    localparam int RESULT_BITS   = 16;
    localparam int CONV_TYP_US   = 16600;   // typical conversion, microseconds
    localparam int CONV_MAX_US   = 23000;   // longest conversion, microseconds
    localparam int CLK_MHZ       = 100;
    localparam int CONV_TYP_CYC  = CONV_TYP_US * CLK_MHZ;
    localparam int CONV_MAX_CYC  = CONV_MAX_US * CLK_MHZ;
    // host serial clock half period in system cycles (80 ns)
    localparam int SCK_HALF_CYC  = 8;
    // host recovery burst length
    localparam int RECOVER_PULSES = 16;
    // idle level of the serial clock per polarity
    localparam logic CPOL_HIGH   = 1'b1;
    localparam logic CPOL_LOW    = 1'b0;
endpackage

// file: rtl/atw_if.sv
`timescale 1ns/100ps
`default_nettype none
// two-wire link: host drives the clock, device drives data; select is tied low
interface atw_if;
    logic sck;
    logic sdo;
    logic cs_n;
    assign cs_n = 1'b0;
    modport dev  (input sck, input cs_n, output sdo);
    modport host (output sck, output cs_n, input sdo);
endinterface
`default_nettype wire

// file: rtl/atw_dev.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// R1: host holds chip select permanently grounded
// R2: device offers no transfer abort
// R3: use two-wire only without sleep needs
// R4: idle-high: conversion end drives data low
// R5: idle-high: sixteen pulses shift result out
// R6: idle-high: seventeenth pulse starts conversion
// R7: idle-low: skip sleep, present sign bit
// R8: idle-low: host times conversion end itself
// R9: idle-low: sixteenth falling edge restarts conversion
// R10: host should prefer idle-high clock
// R11: host checks data low before, high after
// R12: on timeout host sends sixteen recovery pulses
// R13: conversion about 16.6 ms, 23 ms worst
// R14: MSB first, shift on fall, sample rise
// R15: conversion length is a parameter
// R16: clock edges during conversion are ignored

// operation overview
// three states: converting, sleeping with status low, shifting the result
// after reset the converter starts a conversion from count zero
// the conversion length is a count of system cycles, not of link edges
// a simulation shortens it through the parameter, the sequence is unchanged
// busy stays high for the whole conversion and drops with the capture
// the captured value is kept in last_result until the next capture
//
// idle-high clock
// - at conversion end the data line goes low as the status flag
// - the first falling edge leaves sleep and shows the sign bit
// - each later falling edge up to the sixteenth moves to the next lower bit
// - the host samples every bit on the rising edge
// - the seventeenth falling edge starts the next conversion
// - the data line then returns high, which the host checks
//
// idle-low clock
// - sleep is skipped, the sign bit is shown at conversion end
// - no status is visible, so the host must time the conversion itself
// - sixteen rising edges carry the bits to the host
// - the sixteenth falling edge starts the next conversion
//
// link clock handling
// - the link clock comes from another domain and is synchronised
// - only the second flop stage feeds the edge detector
// - the detector resets to the idle-high level the host drives in reset,
//   so no false edge appears when reset is released with the idle-high clock
// - an edge is acted on about three system cycles after the pin moves
// - the host half period must comfortably exceed that delay
//
// limitations
// - with the select tied low there is no way to abort a transfer
// - a lost or extra clock pulse leaves the bit index out of step;
//   with the idle-high clock the host recovers by sending sixteen more pulses
// - edges seen while converting are dropped and never move the index
// - the sample input must be stable at the end of each conversion
// - the clock polarity input must not change during operation
//
// trade-off: the index is a small counter rather than a one-hot mask,
// which keeps the restart test a single compare against the last bit

module atw_dev #(
    parameter int CONV_CYC = atw_pkg::CONV_TYP_CYC
) (
    // system
    input  wire logic                           clk,
    input  wire logic                           rst,
    // link
    atw_if.dev                                  lnk,
    // user side
    input  wire logic                           cpol,
    input  wire logic [atw_pkg::RESULT_BITS-1:0] sample,
    output logic                                busy,
    output logic [atw_pkg::RESULT_BITS-1:0]     last_result
);
    import atw_pkg::*;

    typedef enum {ST_CONV, ST_SLEEP, ST_DATA} atw_dev_state_t;

    logic                    sck_m_r;
    logic                    sck_s_r;
    logic                    sck_d_r;
    logic                    sdo_r;
    logic                    sdo_nxt;
    atw_dev_state_t          st_r;
    atw_dev_state_t          st_nxt;
    logic [31:0]             cnt_r;
    logic [31:0]             cnt_nxt;
    logic [RESULT_BITS-1:0]  sh_r;
    logic [RESULT_BITS-1:0]  sh_nxt;
    logic [4:0]              bit_r;
    logic [4:0]              bit_nxt;
    logic                    busy_r;
    logic                    busy_nxt;
    logic [RESULT_BITS-1:0]  res_r;
    logic [RESULT_BITS-1:0]  res_nxt;
    logic                    fall;

    // two-flop sync of link clock, edge detect on second stage only
    always_ff @(posedge clk) begin
        if (rst) begin
            sck_m_r <= 1'b1;
            sck_s_r <= 1'b1;
            sck_d_r <= 1'b1;
        end else begin
            sck_m_r <= lnk.sck;
            sck_s_r <= sck_m_r;
            sck_d_r <= sck_s_r;
        end
    end
    // only falling edges move the shifter; the host samples on rising ones
    assign fall = ~sck_s_r & sck_d_r;

    // conversion and readout sequencer
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        sh_nxt   = sh_r;
        bit_nxt  = bit_r;
        sdo_nxt  = sdo_r;
        busy_nxt = busy_r;
        res_nxt  = res_r;
        case (st_r)
            ST_CONV: begin
                // R16: edges ignored here
                // R15: parameterised length
                // R13: fixed conversion time
                sdo_nxt  = 1'b1;
                busy_nxt = 1'b1;
                bit_nxt  = 5'h00;
                if (cnt_r >= 32'(CONV_CYC - 1)) begin
                    cnt_nxt  = 32'h0;
                    sh_nxt   = sample;
                    res_nxt  = sample;
                    busy_nxt = 1'b0;
                    if (cpol == CPOL_HIGH) begin
                        // R4: status low on sleep
                        st_nxt  = ST_SLEEP;
                        sdo_nxt = 1'b0;
                    end else begin
                        // R7: sign bit at once
                        st_nxt  = ST_DATA;
                        sdo_nxt = sample[RESULT_BITS-1];
                    end
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            ST_SLEEP: begin
                // first falling edge exposes the sign bit
                if (fall) begin
                    st_nxt  = ST_DATA;
                    sdo_nxt = sh_r[RESULT_BITS-1];
                end
            end
            ST_DATA: begin
                // R2: no abort path, only clock edges advance
                // R14: shift on falling edge
                if (fall) begin
                    bit_nxt = bit_r + 5'h01;
                    sh_nxt  = {sh_r[RESULT_BITS-2:0], 1'b0};
                    sdo_nxt = sh_r[RESULT_BITS-2];
                    if (bit_r == 5'(RESULT_BITS - 1)) begin
                        // R6: 17th pulse restarts
                        // R9: 16th fall restarts
                        st_nxt  = ST_CONV;
                        sdo_nxt = 1'b1;
                        busy_nxt = 1'b1;
                    end
                end
            end
            default: st_nxt = ST_CONV;
        endcase
    end

    // R5: register state
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r   <= ST_CONV;
            cnt_r  <= 32'h0;
            sh_r   <= '0;
            bit_r  <= 5'h00;
            sdo_r  <= 1'b1;
            busy_r <= 1'b1;
            res_r  <= '0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            sh_r   <= sh_nxt;
            bit_r  <= bit_nxt;
            sdo_r  <= sdo_nxt;
            busy_r <= busy_nxt;
            res_r  <= res_nxt;
        end
    end

    // all outputs straight from flops
    assign lnk.sdo     = sdo_r;
    assign busy        = busy_r;
    assign last_result = res_r;
endmodule
`default_nettype wire

// file: dv/atw_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// link checker for the converter and host pair
module atw_monitor #(
    parameter int CONV_CYC = 200
) (
    // system
    input wire logic                            clk,
    input wire logic                            rst,
    // link
    input wire logic                            sck,
    input wire logic                            sdo,
    input wire logic                            cs_n,
    // device user side
    input wire logic                            cpol,
    input wire logic                            busy,
    input wire logic [atw_pkg::RESULT_BITS-1:0] sample
);
    import atw_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] conv_cnt_r;
    logic [31:0] conv_cnt_nxt;
    logic [5:0]  fall_cnt_r;
    logic [5:0]  fall_cnt_nxt;
    logic        sck_r;
    // conversion length and falls between conversions; falls taken raw, the device adds sync delay
    always_comb begin
        conv_cnt_nxt = busy ? conv_cnt_r + 32'h1 : 32'h0;
        fall_cnt_nxt = busy ? 6'h0 : fall_cnt_r + {5'h0, sck_r & ~sck};
    end
    // registers only
    always_ff @(posedge clk) begin
        sck_r <= sck;
        conv_cnt_r <= rst ? 32'h0 : conv_cnt_nxt;
        fall_cnt_r <= rst ? 6'h0 : fall_cnt_nxt;
    end
    cs_low_a: assert property (cs_n == 1'b0)
        else $error("select line not grounded");
    status_low_a: assert property (cpol && $fell(busy) |-> ##[0:2] !sdo)
        else $error("no low status at conversion end");
    sign_first_a: assert property (!cpol && $fell(busy) |-> ##[0:3] (sdo == sample[15]))
        else $error("sign bit not presented");
    busy_high_a: assert property (cpol && busy && $past(busy, 2) |-> sdo)
        else $error("data low while converting");
    conv_len_a: assert property ($fell(busy) |-> conv_cnt_r >= CONV_CYC - 2 && conv_cnt_r <= CONV_CYC + 2)
        else $error("conversion length wrong");
    restart_count_a: assert property ($rose(busy) |-> fall_cnt_r == (cpol ? 6'h11 : 6'h10))
        else $error("restart on wrong falling edge");
    steady_rise_a: assert property (sck && $past(sck, 4) && !$past(busy, 3) |-> $stable(sdo))
        else $error("data moved while clock high");
    quiet_conv_a: assert property (busy && $past(busy, 3) |-> $stable(sdo))
        else $error("data moved during conversion");
    cover property (cpol && $rose(busy));
    cover property (!cpol && $rose(busy));
    cover property (cpol && $fell(busy));
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// both link ends back to back, plus a spare host facing a stuck data line
module testbench;
    import atw_pkg::*;
    localparam int CONV = 200;
    localparam int TOUT = 400;
    logic        clk;
    logic        rst;
    logic        cpol;
    logic        stuck_sdo;
    logic [15:0] sample;
    logic        busy;
    logic [15:0] last_result;
    logic [15:0] data;
    logic        data_valid;
    logic        recover_b;
    logic        recover_a;
    int          rec_cnt_a = 0;
    int          falls_b;
    int          mismatches = 0;
    int          comparisons = 0;
    atw_if lnk ();
    atw_if lnk_b ();
    // the faulty converter never releases its data line
    assign lnk_b.sdo = stuck_sdo;
    atw_dev #(.CONV_CYC(CONV)) atw_dev_inst (
        .clk(clk), .rst(rst), .lnk(lnk.dev), .cpol(cpol),
        .sample(sample), .busy(busy), .last_result(last_result));
    atw_host #(.TIMEOUT_CYC(TOUT)) atw_host_inst (
        .clk(clk), .rst(rst), .lnk(lnk.host), .cpol(cpol),
        .data(data), .data_valid(data_valid), .recover_evt(recover_a));
    atw_host #(.TIMEOUT_CYC(TOUT)) atw_host_b_inst (
        .clk(clk), .rst(rst), .lnk(lnk_b.host), .cpol(1'b1),
        .data(), .data_valid(), .recover_evt(recover_b));
    atw_monitor #(.CONV_CYC(CONV)) atw_monitor_inst (
        .clk(clk), .rst(rst), .sck(lnk.sck), .sdo(lnk.sdo), .cs_n(lnk.cs_n),
        .cpol(cpol), .busy(busy), .sample(sample));
    // 100 MHz system clock
    always #5 clk = ~clk;
    // counts falls of the spare host's clock
    always @(negedge lnk_b.sck) falls_b++;
    // a healthy link must never draw a recovery burst
    always @(posedge clk) if (recover_a === 1'b1) rec_cnt_a++;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic do_reset(input logic pol);
        @(posedge clk);
        #1;
        rst = 1'b1;
        cpol = pol;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
    endtask
    // three back-to-back reads; sample changes once each valid result is seen, before the next capture
    task automatic run_reads(input logic pol);
        logic [15:0] vals [3];
        int          n;
        vals = '{16'h8001, 16'h7FFE, 16'hA5C3};
        sample = vals[0];
        do_reset(pol);
        for (int i = 0; i < 3; i++) begin
            n = 0;
            @(posedge clk);
            #1;
            while (data_valid !== 1'b1 && n < 3000) begin
                @(posedge clk);
                #1;
                n++;
            end
            check({15'h0, data_valid}, 16'h1);
            check(data, vals[i]);
            check(last_result, vals[i]);
            if (pol) check({15'h0, lnk.sdo}, 16'h1);
            if (i < 2) sample = vals[i + 1];
        end
        check(16'(rec_cnt_a), 16'h0);
    endtask
    // a dead converter must draw one recovery burst of sixteen pulses
    task automatic fault_case(input logic level, input int exp_falls);
        int n;
        stuck_sdo = level;
        do_reset(1'b1);
        falls_b = 0;
        n = 0;
        while (recover_b !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({15'h0, recover_b}, 16'h1);
        check(16'(falls_b), 16'(exp_falls));
    endtask
    task automatic final_report();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cpol = 1'b1;
        stuck_sdo = 1'b1;
        sample = 16'h0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        run_reads(1'b1);
        run_reads(1'b0);
        fault_case(1'b1, 16);
        fault_case(1'b0, 33);
        final_report();
    end
    // watchdog well past the roughly five thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
